// File: tsp_consts.svh
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH

// Register byte offsets on the APB
`define TSP_OFF_CTRL 8'h00
`define TSP_OFF_COUNT 8'h04
`define TSP_OFF_CMP 8'h08
`define TSP_OFF_RELOAD 8'h0C
`define TSP_OFF_STATUS 8'h10
`define TSP_OFF_CLEAR 8'h14
`define TSP_OFF_IRQEN 8'h18

// Control register fields
`define TSP_CTRL_EN 0
`define TSP_CTRL_POL 1
`define TSP_CTRL_PRE_LSB 2
`define TSP_CTRL_PRE_MSB 4
`define TSP_CTRL_OUT 8

// Event bit positions in status, clear and enable registers
`define TSP_EVT_RELOAD 0
`define TSP_EVT_MATCH 1
`define TSP_EVT_NUM 2

// Reset values
`define TSP_RST_COUNT 16'h0001
`define TSP_RST_CMP 16'h0000
`define TSP_RST_RELOAD 16'hFFFF
`define TSP_RST_PRE 3'h0

// Count loaded at every reload
`define TSP_RESTART 16'h0001

`endif

// File: tsp_pkg.sv
`default_nettype none
package tsp_pkg;
	// Timer run state, Gray coded along idle, first pass, later periods
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_FIRST = 2'h1,
		ST_PERIOD = 2'h3
	} tsp_state_t;

	typedef logic [15:0] tsp_word_t;

	// Prescale select to division factor, 1 to 128
	function automatic logic [7:0] tsp_factor(input logic [2:0] sel);
		tsp_factor = 8'h01 << sel;
	endfunction : tsp_factor
endpackage : tsp_pkg
`default_nettype wire

// File: tsp_irq_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tsp_irq_if;
	logic [1:0] evt;
	logic clrWr;
	logic enWr;
	logic [1:0] wrData;
	logic [1:0] status;
	logic [1:0] enable;

	modport owner (output evt, output clrWr, output enWr, output wrData,
		input status, input enable);
	modport irqBlk (input evt, input clrWr, input enWr, input wrData,
		output status, output enable);
endinterface : tsp_irq_if
`default_nettype wire

// File: tsp_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module tsp_prescaler (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic run,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [7:0] divCnt_r;
	logic [7:0] limit;

	// Last count of the division cycle
	assign limit = tsp_pkg::tsp_factor(sel) - 8'h01;
	assign tick = ce & run & (divCnt_r == limit);

	// Divider restarts whenever the timer is stopped
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			divCnt_r <= 8'h00;
		end else if (ce) begin
			if (!run || tick) begin
				divCnt_r <= 8'h00;
			end else begin
				divCnt_r <= divCnt_r + 8'h01;
			end
		end
	end
endmodule : tsp_prescaler
`default_nettype wire

// File: tsp_irq.sv
`timescale 1ns/10ps
`default_nettype none
`include "tsp_consts.svh"
module tsp_irq (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	tsp_irq_if.irqBlk bus,
	output logic irq
);
	// Sticky status bits, a new event wins over a clear
	for (genvar g = 0; g < `TSP_EVT_NUM; g++) begin : gStat
		always_ff @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				bus.status[g] <= 1'b0;
			end else if (ce) begin
				if (bus.evt[g]) begin
					bus.status[g] <= 1'b1;
				end else if (bus.clrWr && bus.wrData[g]) begin
					bus.status[g] <= 1'b0;
				end
			end
		end
	end

	// Enable register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus.enable <= 2'h0;
		end else if (ce && bus.enWr) begin
			bus.enable <= bus.wrData;
		end
	end

	// Level interrupt
	assign irq = |(bus.status & bus.enable);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_irq_on_event: assert property (ce && !bus.enWr && |(bus.evt & bus.enable) |=> irq)
		else $error("enabled event did not raise the interrupt");
	a_evt_sticky: assert property (ce && bus.evt[0] ##1 (!ce || !bus.clrWr)[*2] |-> bus.status[0])
		else $error("reload status bit lost");
	c_irq_raise: cover property ($rose(irq));
endmodule : tsp_irq
`default_nettype wire

// File: tsp_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "tsp_consts.svh"
module tsp_timer (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic pwmOut,
	output logic irq
);
	// Registers and run state
	tsp_pkg::tsp_word_t countR;
	tsp_pkg::tsp_word_t cmpR;
	tsp_pkg::tsp_word_t reloadR;
	logic enR;
	logic polR;
	logic [2:0] preR;
	tsp_pkg::tsp_state_t stateR;
	tsp_pkg::tsp_state_t stateNxt;
	logic pwmR;
	// Read path and timer strobes
	logic [31:0] rdataR;
	logic [31:0] rdMux;
	logic hit;
	logic wrAcc;
	logic setup;
	logic run;
	logic tick;
	logic atReload;
	logic atMatch;
	logic reloadEvt;
	logic matchEvt;

	tsp_irq_if irqBus ();

	// Write strobe for one register offset
	function automatic logic isWr(input logic acc, input logic [7:0] a,
		input logic [7:0] off);
		isWr = acc && (a == off);
	endfunction : isWr

	// APB phases; every access finishes in one cycle while enabled
	assign setup = ce & psel & ~penable;
	assign wrAcc = ce & psel & penable & pwrite;
	assign pready = ce;
	assign pslverr = psel & penable & ~hit;
	assign prdata = rdataR;

	// Read decode
	always_comb begin
		rdMux = 32'h0000_0000;
		hit = 1'b1;
		if (paddr == `TSP_OFF_CTRL) begin
			rdMux[`TSP_CTRL_EN] = enR;
			rdMux[`TSP_CTRL_POL] = polR;
			rdMux[`TSP_CTRL_PRE_MSB:`TSP_CTRL_PRE_LSB] = preR;
			rdMux[`TSP_CTRL_OUT] = pwmR;
		end else if (paddr == `TSP_OFF_COUNT) begin
			rdMux[15:0] = countR;
		end else if (paddr == `TSP_OFF_CMP) begin
			rdMux[15:0] = cmpR;
		end else if (paddr == `TSP_OFF_RELOAD) begin
			rdMux[15:0] = reloadR;
		end else if (paddr == `TSP_OFF_STATUS) begin
			rdMux[1:0] = irqBus.status;
		end else if (paddr == `TSP_OFF_CLEAR) begin
			rdMux = 32'h0000_0000; // Write-only, reads zero
		end else if (paddr == `TSP_OFF_IRQEN) begin
			rdMux[1:0] = irqBus.enable;
		end else begin
			hit = 1'b0;
		end
	end

	// Read data captured in the setup cycle, stable through access
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdataR <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			rdataR <= rdMux;
		end
	end

	// Control register: enable, polarity, prescale
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			enR <= 1'b0;
			polR <= 1'b0;
			preR <= `TSP_RST_PRE;
		end else if (isWr(wrAcc, paddr, `TSP_OFF_CTRL)) begin
			enR <= pwdata[`TSP_CTRL_EN];
			polR <= pwdata[`TSP_CTRL_POL];
			preR <= pwdata[`TSP_CTRL_PRE_MSB:`TSP_CTRL_PRE_LSB];
		end
	end

	// Compare and reload values
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmpR <= `TSP_RST_CMP;
			reloadR <= `TSP_RST_RELOAD;
		end else begin
			if (isWr(wrAcc, paddr, `TSP_OFF_CMP)) begin
				cmpR <= pwdata[15:0];
			end
			if (isWr(wrAcc, paddr, `TSP_OFF_RELOAD)) begin
				reloadR <= pwdata[15:0];
			end
		end
	end

	// Prescaled count tick
	assign run = enR & (stateR != tsp_pkg::ST_IDLE);

	tsp_prescaler uPre (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.run(run),
		.sel(preR),
		.tick(tick)
	);

	// Reload and match decode, qualified by the prescaler tick
	assign atReload = (countR == reloadR);
	assign atMatch = (countR == cmpR) & ~atReload;
	assign reloadEvt = tick & atReload;
	assign matchEvt = tick & atMatch;

	// Run state: first pass from the loaded count, then full periods
	always_comb begin
		stateNxt = stateR;
		case (stateR)
			tsp_pkg::ST_IDLE: begin
				if (enR) begin
					stateNxt = tsp_pkg::ST_FIRST;
				end
			end
			tsp_pkg::ST_FIRST: begin
				if (!enR) begin
					stateNxt = tsp_pkg::ST_IDLE;
				end else if (reloadEvt) begin
					stateNxt = tsp_pkg::ST_PERIOD;
				end
			end
			tsp_pkg::ST_PERIOD: begin
				if (!enR) begin
					stateNxt = tsp_pkg::ST_IDLE;
				end
			end
			default: begin
				stateNxt = tsp_pkg::ST_IDLE;
			end
		endcase
	end

	// Run state register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stateR <= tsp_pkg::ST_IDLE;
		end else if (ce) begin
			stateR <= stateNxt;
		end
	end

	// Counter: software load, count up, restart at reload
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			countR <= `TSP_RST_COUNT;
		end else if (isWr(wrAcc, paddr, `TSP_OFF_COUNT)) begin
			countR <= pwdata[15:0];
		end else if (reloadEvt) begin
			countR <= `TSP_RESTART;
		end else if (tick) begin
			countR <= countR + 16'h0001;
		end
	end

	// Output level: starting level from polarity, flip on match, restore at reload
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pwmR <= 1'b0;
		end else if (ce) begin
			if (stateR == tsp_pkg::ST_IDLE) begin
				pwmR <= polR;
			end else if (reloadEvt) begin
				pwmR <= polR;
			end else if (matchEvt) begin
				pwmR <= ~polR;
			end
		end
	end

	// Output pin straight from its flip-flop
	assign pwmOut = pwmR;

	// Timer events into the interrupt block
	assign irqBus.evt[`TSP_EVT_RELOAD] = reloadEvt;
	assign irqBus.evt[`TSP_EVT_MATCH] = matchEvt;
	assign irqBus.clrWr = isWr(wrAcc, paddr, `TSP_OFF_CLEAR);
	assign irqBus.enWr = isWr(wrAcc, paddr, `TSP_OFF_IRQEN);
	assign irqBus.wrData = pwdata[1:0];

	tsp_irq uIrq (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.bus(irqBus),
		.irq(irq)
	);

	// Helper logic for period and duty checks
	logic cfgWr;
	logic cfgOkR;
	logic [23:0] periodCntR;
	logic [23:0] expPeriod;
	tsp_pkg::tsp_word_t highTicksR;
	tsp_pkg::tsp_word_t highSum;

	assign cfgWr = wrAcc & ((paddr == `TSP_OFF_CTRL) | (paddr == `TSP_OFF_CMP)
		| (paddr == `TSP_OFF_RELOAD) | (paddr == `TSP_OFF_COUNT));
	assign expPeriod = 24'({8'h00, reloadR} * {16'h0000, tsp_pkg::tsp_factor(preR)});
	assign highSum = highTicksR + {15'h0000, pwmR};

	// Configuration untouched since the last reload
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfgOkR <= 1'b0;
		end else if (ce) begin
			if (cfgWr || (stateR == tsp_pkg::ST_IDLE)) begin
				cfgOkR <= 1'b0;
			end else if (reloadEvt) begin
				cfgOkR <= 1'b1;
			end
		end
	end

	// Enabled cycles since the last reload
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			periodCntR <= 24'h000000;
		end else if (ce) begin
			if (reloadEvt) begin
				periodCntR <= 24'h000001;
			end else begin
				periodCntR <= periodCntR + 24'h000001;
			end
		end
	end

	// Ticks spent high since the last reload
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			highTicksR <= 16'h0000;
		end else if (reloadEvt) begin
			highTicksR <= 16'h0000;
		end else if (tick && pwmR) begin
			highTicksR <= highTicksR + 16'h0001;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Polarity cleared: starts low, rises on compare match
	a_low_start: assert property ($rose(run) && !polR |-> !pwmR)
		else $error("output did not start low");
	a_high_on_match: assert property (matchEvt && !polR |=> pwmR)
		else $error("output did not rise on compare match");

	// Reload restores the starting level; later periods start from one
	a_reload_restart: assert property (reloadEvt && !cfgWr |=>
		countR == `TSP_RESTART && pwmR == $past(polR))
		else $error("reload did not restart count and level");
	a_later_from_one: assert property ($rose(stateR == tsp_pkg::ST_PERIOD) && !$past(cfgWr)
		|-> countR == `TSP_RESTART)
		else $error("later period did not start at one");

	// Period length and high time once a whole period ran untouched
	a_period_len: assert property (reloadEvt && cfgOkR |-> periodCntR == expPeriod)
		else $error("period length differs from reload times prescale");
	a_duty_low_pol: assert property (reloadEvt && cfgOkR && !polR && cmpR != 16'h0000
		&& cmpR < reloadR |-> highSum == reloadR - cmpR)
		else $error("high time wrong with polarity cleared");
	a_duty_high_pol: assert property (reloadEvt && cfgOkR && polR && cmpR != 16'h0000
		&& cmpR < reloadR |-> highSum == cmpR)
		else $error("high time wrong with polarity set");

	// First pass counts up from the loaded value
	a_first_count: assert property (tick && stateR == tsp_pkg::ST_FIRST && !atReload
		&& !cfgWr |=> countR == $past(countR) + 16'h0001)
		else $error("first pass did not count up from the loaded value");

	// Polarity set: starts high, falls on compare match
	a_high_start: assert property ($rose(run) && polR |-> pwmR)
		else $error("output did not start high");
	a_low_on_match: assert property (matchEvt && polR ##1 !reloadEvt |-> !pwmR)
		else $error("output did not fall on compare match");

	// Idle output sits at the starting level
	a_idle_level: assert property (ce && stateR == tsp_pkg::ST_IDLE
		|=> pwmR == $past(polR))
		else $error("idle output differs from the starting level");

	// Count moves only on prescaler ticks or a software load
	a_count_hold: assert property (ce && !tick && !cfgWr |=> $stable(countR))
		else $error("count moved between prescaler ticks");

	// Clock enable low freezes counter, output and run state
	a_freeze_state: assert property (!ce |=> $stable(countR) && $stable(pwmR)
		&& $stable(stateR))
		else $error("state moved while the clock enable was low");

	// Writes land at the access edge; unmapped writes change nothing
	a_wr_compare: assert property (isWr(wrAcc, paddr, `TSP_OFF_CMP)
		|=> cmpR == $past(pwdata[15:0]))
		else $error("compare write did not land");
	a_wr_reload: assert property (isWr(wrAcc, paddr, `TSP_OFF_RELOAD)
		|=> reloadR == $past(pwdata[15:0]))
		else $error("reload write did not land");
	a_unmapped_wr: assert property (wrAcc && !hit |=> $stable(cmpR) && $stable(reloadR)
		&& $stable(enR))
		else $error("unmapped write changed a register");

	// Events reach their sticky status bits
	a_match_status: assert property (matchEvt |=> irqBus.status[`TSP_EVT_MATCH])
		else $error("match event did not set its status bit");
	a_reload_status: assert property (reloadEvt |=> irqBus.status[`TSP_EVT_RELOAD])
		else $error("reload event did not set its status bit");

	// Main scenarios
	c_second_period: cover property (reloadEvt && cfgOkR);
	c_pol_match: cover property (matchEvt && polR);
	c_odd_start: cover property ($rose(run) && countR != `TSP_RESTART);
	c_irq_hit: cover property (reloadEvt && irqBus.enable[`TSP_EVT_RELOAD]);
endmodule : tsp_timer
`default_nettype wire

// File: tsp_pin_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// Load on the timer output pin; measures the length of each high and low run
module tsp_pin_monitor (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic pin,
	output logic [15:0] highLen,
	output logic [15:0] lowLen,
	output logic [15:0] edgeCnt
);
	logic [15:0] runLen_r;
	logic pinLast_r;

	// Run length in cycles, stored when the pin level changes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			runLen_r <= 16'h0000;
			pinLast_r <= 1'b0;
			highLen <= 16'h0000;
			lowLen <= 16'h0000;
			edgeCnt <= 16'h0000;
		end else begin
			pinLast_r <= pin;
			if (pin !== pinLast_r) begin
				runLen_r <= 16'h0001;
				edgeCnt <= edgeCnt + 16'h0001;
				if (pinLast_r) begin
					highLen <= runLen_r;
				end else begin
					lowLen <= runLen_r;
				end
			end else begin
				runLen_r <= runLen_r + 16'h0001;
			end
		end
	end
endmodule : tsp_pin_monitor
`default_nettype wire

// File: timer_single_output_pwm_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "tsp_consts.svh"
module timer_single_output_pwm_tb_top;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pwmOut;
	logic irq;
	logic [15:0] highLen;
	logic [15:0] lowLen;
	logic [15:0] edgeCnt;
	logic [15:0] e0;
	logic [31:0] rd;
	logic err;
	int bad_count = 0;
	int checked = 0;
	int n;
	int k;
	int f;
	// Mode table: polarity, prescale select, start count, compare, reload
	logic pol [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [2:0] sel [5] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h3};
	logic [15:0] stv [5] = '{16'h0001, 16'h0001, 16'h0004, 16'h0001, 16'h0003};
	logic [15:0] cmp [5] = '{16'h0001, 16'h0002, 16'h0002, 16'h0001, 16'h0003};
	logic [15:0] rel [5] = '{16'h0003, 16'h0005, 16'h0005, 16'h0003, 16'h0004};
	logic [31:0] rstVal [7] = '{32'h0, 32'h1, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};

	// System clock, 20 ns period
	always #10 clk_sys = ~clk_sys;

	tsp_timer dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwmOut(pwmOut), .irq(irq));
	tsp_pin_monitor load (.clk_sys(clk_sys), .rst(rst), .pin(pwmOut), .highLen(highLen),
		.lowLen(lowLen), .edgeCnt(edgeCnt));

	// Verdict and end of run
	task automatic end_of_test();
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	// Compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// A wait that used up its bound ends the run
	task automatic tmo(input int cnt, input int lim);
		if (cnt >= lim) begin
			bad_count++;
			end_of_test();
		end
	endtask : tmo

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int c = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			c++;
		end while (pready !== 1'b1 && c < 50);
		tmo(c, 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Read a register and compare it
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rchk

	// Main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rchk(8'(4 * i), rstVal[i]);
		end
		apb(1'b0, 8'h1C, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, 8'h1C, 32'h0000_FFFF);
		chk({31'h0, err}, 32'h1);
		rchk(`TSP_OFF_CMP, 32'h0);
		apb(1'b1, `TSP_OFF_IRQEN, 32'h3);
		chk({31'h0, irq}, 32'h0);
		for (int i = 0; i < 5; i++) begin
			f = 1 << sel[i];
			apb(1'b1, `TSP_OFF_CTRL, {27'h0, sel[i], pol[i], 1'b0});
			apb(1'b1, `TSP_OFF_COUNT, {16'h0, stv[i]});
			apb(1'b1, `TSP_OFF_CMP, {16'h0, cmp[i]});
			apb(1'b1, `TSP_OFF_RELOAD, {16'h0, rel[i]});
			chk({31'h0, pwmOut}, {31'h0, pol[i]});
			apb(1'b1, `TSP_OFF_CTRL, {27'h0, sel[i], pol[i], 1'b1});
			k = (stv[i] <= cmp[i]) ? cmp[i] - stv[i] + 1 : rel[i] - stv[i] + 1 + cmp[i];
			n = 0;
			do begin
				@(posedge clk_sys);
				n++;
				#1;
			end while (pwmOut === pol[i] && n < 2000);
			tmo(n, 2000);
			chk(n, k * f + 1);
			e0 = edgeCnt;
			n = 0;
			while (edgeCnt < e0 + 16'h0003 && n < 3000) begin
				@(posedge clk_sys);
				n++;
				#1;
			end
			tmo(n, 3000);
			chk({16'h0, pol[i] ? lowLen : highLen}, (rel[i] - cmp[i]) * f);
			chk({16'h0, pol[i] ? highLen : lowLen}, cmp[i] * f);
		end
		@(posedge clk_sys);
		ce <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk({31'h0, pready}, 32'h0);
		ce <= 1'b1;
		apb(1'b1, `TSP_OFF_CTRL, 32'h0);
		rchk(`TSP_OFF_STATUS, 32'h3);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `TSP_OFF_IRQEN, 32'h0);
		rchk(`TSP_OFF_IRQEN, 32'h0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `TSP_OFF_IRQEN, 32'h1);
		rchk(`TSP_OFF_IRQEN, 32'h1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `TSP_OFF_CLEAR, 32'h1);
		rchk(`TSP_OFF_STATUS, 32'h2);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `TSP_OFF_IRQEN, 32'h2);
		rchk(`TSP_OFF_IRQEN, 32'h2);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `TSP_OFF_CLEAR, 32'h2);
		rchk(`TSP_OFF_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		end_of_test();
	end
endmodule : timer_single_output_pwm_tb_top
`default_nettype wire
